// File: include/gate_cond_pkg.sv
/*
  Constants for the gate output conditioning block: register offsets,
  field positions, reset values and dead-time timing.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package gate_cond_pkg;
    localparam logic [7:0] OFS_MASK_EN = 8'h00;
    localparam logic [7:0] OFS_MASK_VAL = 8'h04;
    localparam logic [7:0] OFS_DEAD_TIME = 8'h08;
    localparam logic [7:0] OFS_POLARITY = 8'h0C;
    localparam logic [7:0] OFS_MODE_CTRL = 8'h10;
    localparam logic [7:0] OFS_HALL_DATA = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam int CHAN_W = 6;
    localparam logic [5:0] RST_MASK = 6'h00;
    localparam logic [7:0] RST_DEAD = 8'h00;
    localparam logic [5:0] RST_POL = 6'h00;
    // Dead-time register fields
    localparam int DT_CLK_MSB = 7;
    localparam int DT_CLK_LSB = 6;
    localparam int DT_EN_BIT = 5;
    localparam int DT_CNT_MSB = 4;
    // Mode control fields
    localparam int MODE_MASK_SEL = 0;
    localparam int MODE_BRAKE = 1;
    localparam int MODE_FAULT_SEL = 2;
    localparam int MODE_HALL_IN = 3;
    localparam int MODE_OUT_EN = 4;
    localparam logic [4:0] RST_MODE = 5'h00;
    // Channel index of each high side; low side is index plus one
    localparam logic [5:0] HIGH_SIDES = 6'h15;
    localparam logic [5:0] LOW_SIDES = 6'h2A;
endpackage

// File: core/gate_output_cond.sv
/*
  Gate output conditioning: masking, protection and brake overrides,
  rising-edge dead time, staggered pair guard and pin polarity, plus
  the Hall decoder input source select. APB slave for the registers.
  Assumes pwm and hall inputs are synchronous to clk_i except the
  hall sensor and alt pins and the protect pin, which are synchronised here.
*/
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Mask enable set: channel driven by its mask data, PWM blocked
// - Mask enable clear: PWM passes unchanged
// - Mask data 0 drives low, 1 drives high, only when masked
// - Brake wins all: high sides 0, low sides 1
// - Protect with select 0: all outputs 0, free running
// - Protect with select 1: high sides 0, low sides 1
// - Dead time delays every rising edge of each output
// - Falling edges pass with no delay
// - Clock select 00/01/10/11 gives system clock divided by 1/2/4/8
// - Dead time enable bit 0 disables, 1 enables insertion
// - Dead time is count plus one dead-time clock periods
// - Pair with both sides high is forced to both 0
// - Polarity bit 1 inverts its pin, bit 0 is phase A high
// - After reset all six gate pins are high impedance
// - Hall mode 1: decoder takes the sensor inputs via source select
// - Hall mode 0: decoder takes software hall values
// - Upper bits 7 and 6 of mask and polarity registers read 0
// - Software mask path used only when mask mode select is 1
// - Both of a pair masked with data 1 forces the pair to 0
// - Fault select 0 gives all 0, 1 gives brake pattern
module gate_output_cond #(
    parameter int CHANNELS = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // PWM and hardware mask sources, channel 0 is phase A high
    input wire logic [5:0] pwm_gen_i,
    input wire logic [5:0] hw_mask_i,
    // Protection event, asynchronous pin
    input wire logic protect_i,
    // Hall sources
    input wire logic [2:0] hall_sensor_inputs_i,
    input wire logic [2:0] hall_alt_inputs_i,
    input wire logic hall_src_sel_i,
    output logic [2:0] hall_decoder_o,
    // Gate pins, order a_high a_low b_high b_low c_high c_low
    output logic [5:0] gate_pin_o,
    output logic [5:0] gate_pin_oe_o
);
    logic [5:0] mask_enable_reg;
    logic [5:0] mask_value_reg;
    logic [7:0] dead_time_reg;
    logic [5:0] polarity_reg;
    logic [4:0] mode_reg;
    logic [2:0] soft_hall_values;
    logic [5:0] drv_masked;
    logic [5:0] drv_override;
    logic [5:0] dt_out;
    logic [5:0] stagger_out;
    logic [5:0] pin_q;
    logic [2:0] hall_meta;
    logic [2:0] hall_sync;
    logic [2:0] alt_meta;
    logic [2:0] alt_sync;
    logic [1:0] prot_meta;
    logic prot_sync;
    logic [2:0] prescale;
    logic dt_tick;
    logic [1:0] dt_sel;
    logic [5:0] dt_busy;
    logic [5:0] [4:0] dt_cnt;
    logic [5:0] dt_prev;
    logic wr_en;
    logic [31:0] next_rdata;

    function automatic logic [5:0] pair_conflict(input logic [5:0] v);
        logic [5:0] r;
        r = '0;
        for (int p = 0; p < 3; p++) begin
            r[2*p] = v[2*p] & v[2*p+1];
            r[2*p+1] = v[2*p] & v[2*p+1];
        end
        return r;
    endfunction

    // APB: zero wait states, unmapped addresses read 0 and raise pslverr
    assign pready_o = 1'b1;
    assign wr_en = psel_i & penable_i & pwrite_i & pstrb_i[0];

    function automatic logic mapped(input logic [7:0] a);
        return a == gate_cond_pkg::OFS_MASK_EN || a == gate_cond_pkg::OFS_MASK_VAL ||
            a == gate_cond_pkg::OFS_DEAD_TIME || a == gate_cond_pkg::OFS_POLARITY ||
            a == gate_cond_pkg::OFS_MODE_CTRL || a == gate_cond_pkg::OFS_HALL_DATA ||
            a == gate_cond_pkg::OFS_STATUS;
    endfunction

    assign pslverr_o = psel_i & penable_i & ~mapped(paddr_i);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_enable_reg <= gate_cond_pkg::RST_MASK;
            mask_value_reg <= gate_cond_pkg::RST_MASK;
            dead_time_reg <= gate_cond_pkg::RST_DEAD;
            polarity_reg <= gate_cond_pkg::RST_POL;
            mode_reg <= gate_cond_pkg::RST_MODE;
            soft_hall_values <= 3'h0;
        end else if (wr_en) begin
            unique case (paddr_i)
                gate_cond_pkg::OFS_MASK_EN: mask_enable_reg <= pwdata_i[5:0];
                gate_cond_pkg::OFS_MASK_VAL: mask_value_reg <= pwdata_i[5:0];
                gate_cond_pkg::OFS_DEAD_TIME: dead_time_reg <= pwdata_i[7:0];
                gate_cond_pkg::OFS_POLARITY: polarity_reg <= pwdata_i[5:0];
                gate_cond_pkg::OFS_MODE_CTRL: mode_reg <= pwdata_i[4:0];
                gate_cond_pkg::OFS_HALL_DATA: soft_hall_values <= pwdata_i[2:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (paddr_i)
            gate_cond_pkg::OFS_MASK_EN: next_rdata[5:0] = mask_enable_reg;
            gate_cond_pkg::OFS_MASK_VAL: next_rdata[5:0] = mask_value_reg;
            gate_cond_pkg::OFS_DEAD_TIME: next_rdata[7:0] = dead_time_reg;
            gate_cond_pkg::OFS_POLARITY: next_rdata[5:0] = polarity_reg;
            gate_cond_pkg::OFS_MODE_CTRL: next_rdata[4:0] = mode_reg;
            gate_cond_pkg::OFS_HALL_DATA: next_rdata[2:0] = soft_hall_values;
            gate_cond_pkg::OFS_STATUS: next_rdata[15:0] = {prot_sync, hall_decoder_o, pin_q, dt_busy};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data registered in the setup cycle so it is stable in access
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i & ~penable_i & ~pwrite_i) begin
            prdata_o <= next_rdata;
        end
    end

    // Two-flop synchronisers for pins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hall_meta <= 3'h0;
            hall_sync <= 3'h0;
            alt_meta <= 3'h0;
            alt_sync <= 3'h0;
            prot_meta <= 2'h0;
        end else begin
            hall_meta <= hall_sensor_inputs_i;
            hall_sync <= hall_meta;
            alt_meta <= hall_alt_inputs_i;
            alt_sync <= alt_meta;
            prot_meta <= {prot_meta[0], protect_i};
        end
    end
    assign prot_sync = prot_meta[1];

    // Hall decoder input source
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hall_decoder_o <= 3'h0;
        end else if (mode_reg[gate_cond_pkg::MODE_HALL_IN]) begin
            hall_decoder_o <= hall_src_sel_i ? alt_sync : hall_sync;
        end else begin
            hall_decoder_o <= soft_hall_values;
        end
    end

    // Masking then protection then brake
    always_comb begin
        if (mode_reg[gate_cond_pkg::MODE_MASK_SEL]) begin
            for (int c = 0; c < 6; c++) begin
                drv_masked[c] = mask_enable_reg[c] ? mask_value_reg[c] : pwm_gen_i[c];
            end
            drv_masked = drv_masked & ~pair_conflict(mask_enable_reg & mask_value_reg);
        end else begin
            drv_masked = hw_mask_i;
        end
        drv_override = drv_masked;
        if (prot_sync) begin
            drv_override = mode_reg[gate_cond_pkg::MODE_FAULT_SEL] ?
                gate_cond_pkg::LOW_SIDES : 6'h00;
        end
        if (mode_reg[gate_cond_pkg::MODE_BRAKE]) begin
            drv_override = gate_cond_pkg::LOW_SIDES;
        end
    end

    // Dead-time clock tick: system clock divided by 1, 2, 4 or 8
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prescale <= 3'h0;
        end else begin
            prescale <= prescale + 3'h1;
        end
    end
    assign dt_sel = dead_time_reg[gate_cond_pkg::DT_CLK_MSB:gate_cond_pkg::DT_CLK_LSB];
    always_comb begin
        unique case (dt_sel)
            2'b00: dt_tick = 1'b1;
            2'b01: dt_tick = prescale[0] == 1'b1;
            2'b10: dt_tick = prescale[1:0] == 2'h3;
            default: dt_tick = prescale == 3'h7;
        endcase
    end

    // A rising edge starts a count of count+1 ticks; a fall cancels it at once.
    // Delay is up to one tick coarse because ticks are free running.
    generate
        for (genvar g = 0; g < 6; g++) begin : g_dead
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    dt_busy[g] <= 1'b0;
                    dt_cnt[g] <= 5'h00;
                    dt_prev[g] <= 1'b0;
                end else begin
                    dt_prev[g] <= drv_override[g];
                    if (!drv_override[g]) begin
                        dt_busy[g] <= 1'b0;
                    end else if (!dt_prev[g] && dead_time_reg[gate_cond_pkg::DT_EN_BIT]) begin
                        dt_busy[g] <= 1'b1;
                        dt_cnt[g] <= dead_time_reg[gate_cond_pkg::DT_CNT_MSB:0];
                    end else if (dt_busy[g] && dt_tick) begin
                        if (dt_cnt[g] == 5'h00) begin
                            dt_busy[g] <= 1'b0;
                        end else begin
                            dt_cnt[g] <= dt_cnt[g] - 5'h01;
                        end
                    end
                end
            end
            assign dt_out[g] = drv_override[g] & ~dt_busy[g] &
                ~(~dt_prev[g] & dead_time_reg[gate_cond_pkg::DT_EN_BIT]);
        end
    endgenerate

    assign stagger_out = dt_out & ~pair_conflict(dt_out);

    // Pins are registered; output enable set by software, clear after reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_q <= 6'h00;
        end else begin
            pin_q <= stagger_out ^ polarity_reg;
        end
    end
    assign gate_pin_o = pin_q;
    assign gate_pin_oe_o = {6{mode_reg[gate_cond_pkg::MODE_OUT_EN]}};

    a_brake_pattern: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg[gate_cond_pkg::MODE_BRAKE] |-> drv_override == gate_cond_pkg::LOW_SIDES)
        else $error("brake pattern wrong");
    a_fault_free: assert property (@(posedge clk_i) disable iff (rst_i)
        prot_sync && !mode_reg[gate_cond_pkg::MODE_BRAKE] &&
        !mode_reg[gate_cond_pkg::MODE_FAULT_SEL] |-> drv_override == 6'h00)
        else $error("free running pattern wrong");
    a_fault_brake: assert property (@(posedge clk_i) disable iff (rst_i)
        prot_sync && mode_reg[gate_cond_pkg::MODE_FAULT_SEL] |->
        drv_override == gate_cond_pkg::LOW_SIDES)
        else $error("fault brake pattern wrong");
    a_mask_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg[gate_cond_pkg::MODE_MASK_SEL] && mask_enable_reg[0] && !mask_enable_reg[1] |->
        drv_masked[0] == mask_value_reg[0])
        else $error("mask data not applied");
    a_mask_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg[gate_cond_pkg::MODE_MASK_SEL] && mask_enable_reg == 6'h00 |->
        drv_masked == pwm_gen_i)
        else $error("pwm not passed");
    a_fall_fast: assert property (@(posedge clk_i) disable iff (rst_i)
        !drv_override[0] |=> !dt_busy[0])
        else $error("falling edge delayed");
    sequence s_rise0;
        dead_time_reg[gate_cond_pkg::DT_EN_BIT] && drv_override[0] && !dt_prev[0];
    endsequence
    a_rise_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rise0 |-> !dt_out[0] ##1 (!dt_out[0] || !drv_override[0]))
        else $error("rising edge not delayed");
    a_stagger_pair: assert property (@(posedge clk_i) disable iff (rst_i)
        !(stagger_out[0] && stagger_out[1]))
        else $error("pair both on");
    a_pin_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> pin_q == ($past(stagger_out) ^ $past(polarity_reg)))
        else $error("polarity wrong");
    a_hall_soft: assert property (@(posedge clk_i) disable iff (rst_i)
        !mode_reg[gate_cond_pkg::MODE_HALL_IN] && $stable(soft_hall_values) |=>
        hall_decoder_o == $past(soft_hall_values))
        else $error("soft hall not used");

    // Divider checks: a fast tick here would shorten every dead time
    a_tick_sys: assert property (@(posedge clk_i) disable iff (rst_i)
        dt_sel == 2'b00 |-> dt_tick)
        else $error("tick missing at full rate");

    sequence s_half_tick;
        dt_sel == 2'b01 && dt_tick;
    endsequence
    a_tick_half: assert property (@(posedge clk_i) disable iff (rst_i)
        s_half_tick ##1 dt_sel == 2'b01 |-> !dt_tick)
        else $error("half rate tick too often");

    a_dt_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !dead_time_reg[gate_cond_pkg::DT_EN_BIT] && dt_busy == 6'h00 |->
        dt_out == drv_override)
        else $error("dead time applied while disabled");

    a_dt_load: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rise0 |=> dt_busy[0] && dt_cnt[0] == $past(dead_time_reg[gate_cond_pkg::DT_CNT_MSB:0]))
        else $error("dead time count not loaded");

    a_fall_out: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(drv_override[0]) |-> !dt_out[0])
        else $error("falling edge held");

    a_stagger_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        !(dt_out[0] && dt_out[1]) |-> stagger_out[1:0] == dt_out[1:0])
        else $error("stagger blocked a legal pair");

    a_stagger_b: assert property (@(posedge clk_i) disable iff (rst_i)
        !(stagger_out[2] && stagger_out[3]))
        else $error("pair b both on");

    a_stagger_c: assert property (@(posedge clk_i) disable iff (rst_i)
        !(stagger_out[4] && stagger_out[5]))
        else $error("pair c both on");

    a_pair_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg[gate_cond_pkg::MODE_MASK_SEL] && &mask_enable_reg[1:0] &&
        &mask_value_reg[1:0] |-> drv_masked[1:0] == 2'b00)
        else $error("masked pair not forced off");

    a_hw_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        !mode_reg[gate_cond_pkg::MODE_MASK_SEL] |-> drv_masked == hw_mask_i)
        else $error("hardware mask not used");

    a_mask_high: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg[gate_cond_pkg::MODE_MASK_SEL] && mask_enable_reg[2] && mask_value_reg[2] &&
        !mask_enable_reg[3] |-> drv_masked[2])
        else $error("mask data high not applied");

    a_mask_low: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg[gate_cond_pkg::MODE_MASK_SEL] && mask_enable_reg[4] && !mask_value_reg[4] |->
        !drv_masked[4])
        else $error("mask data low not applied");

    a_hall_sensor: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg[gate_cond_pkg::MODE_HALL_IN] && !hall_src_sel_i |=>
        hall_decoder_o == $past(hall_sync))
        else $error("hall sensor not used");

    a_prdata_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
        else $error("read data moved in access");

    a_fault_pair: assert property (@(posedge clk_i) disable iff (rst_i)
        prot_sync && !mode_reg[gate_cond_pkg::MODE_BRAKE] |->
        drv_override[1:0] == {mode_reg[gate_cond_pkg::MODE_FAULT_SEL], 1'b0})
        else $error("fault select pattern wrong");
endmodule
`default_nettype wire

// File: test/gate_driver_model.sv
/*
  Model of the external gate driver transistor pairs on the six gate pins.
  Assumes pins are sampled on clk_i and undriven pins are pulled low.
*/
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model (
    // Clock
    input wire logic clk_i,
    // Gate pins
    input wire logic [5:0] gate_pin_i,
    input wire logic [5:0] gate_pin_oe_i,
    // Observed state
    output logic [5:0] gate_level_o,
    output logic shoot_o
);
    // A released pin sits at the pull-down level, never at its last value
    assign gate_level_o = gate_pin_i & gate_pin_oe_i;
    initial shoot_o = 1'b0;
    // Sticky: a pair turned fully on is a short across the supply
    always @(posedge clk_i) begin
        if (|(gate_level_o & (gate_level_o >> 1) & gate_cond_pkg::HIGH_SIDES)) begin
            shoot_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: test/gate_output_cond_bench.sv
/*
  Self-checking bench: APB register tasks and sequences over the gate path.
  Assumes zero-wait APB and a 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module gate_output_cond_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hall_sel = 1'b0, protect = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, rq;
    logic pready, pslverr, re, shoot;
    logic [5:0] pwm = 6'h00, hw_mask = 6'h00, pin, oe, level;
    logic [2:0] hall_s = 3'h0, hall_a = 3'h0, hall_dec;
    int error_cnt = 0, n_checks = 0, n;
    always #2.5 clk_i = ~clk_i;
    gate_output_cond dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pwm_gen_i(pwm),
        .hw_mask_i(hw_mask), .protect_i(protect), .hall_sensor_inputs_i(hall_s),
        .hall_alt_inputs_i(hall_a), .hall_src_sel_i(hall_sel), .hall_decoder_o(hall_dec),
        .gate_pin_o(pin), .gate_pin_oe_o(oe));
    gate_driver_model drv_u (.clk_i(clk_i), .gate_pin_i(pin), .gate_pin_oe_i(oe),
        .gate_level_o(level), .shoot_o(shoot));
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (pready !== 1'b1 && i < 50);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            test_done();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk("register read", exp, rq);
    endtask
    task automatic pin_chk(input logic [5:0] p, input logic [5:0] exp);
        @(posedge clk_i);
        pwm <= p;
        repeat (6) @(posedge clk_i);
        #1 chk("gate pins", {26'h0, exp}, {26'h0, pin});
    endtask
    task automatic dt_run(input logic [1:0] sel, input logic [4:0] cnt, input int div);
        int exp;
        apb(1'b1, gate_cond_pkg::OFS_DEAD_TIME, {24'h0, sel, 1'b1, cnt});
        pin_chk(6'h00, 6'h00);
        @(posedge clk_i);
        pwm <= 6'h01;
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (pin[0] !== 1'b1 && n < 400);
        exp = (cnt + 1) * div;
        n_checks++;
        if (n < exp - div + 1 || n > exp + 3) begin
            error_cnt++;
            $display("[FAIL] dead time expected %0d seen %0d", exp, n);
        end
        if (pin[0] !== 1'b1) test_done();
        @(posedge clk_i);
        pwm <= 6'h00;
        repeat (2) @(posedge clk_i);
        #1 chk("falling edge", 32'h0, {31'h0, pin[0]});
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 chk("output enable", 32'h0, {26'h0, oe});
        for (int a = 0; a < 8'h1C; a += 4) rd_chk(a[7:0], 32'h0);
        for (int a = 0; a < 8'h10; a += 4) begin
            apb(1'b1, a[7:0], 32'h000000FF);
            rd_chk(a[7:0], (a == 8) ? 32'hFF : 32'h3F);
            apb(1'b1, a[7:0], 32'h00000000);
        end
        rd_chk(8'h1C, 32'h0);
        chk("slave error", 32'h1, {31'h0, re});
        apb(1'b1, gate_cond_pkg::OFS_MODE_CTRL, 32'h11);
        pin_chk(6'h15, 6'h15);
        chk("output enable", 32'h3F, {26'h0, oe});
        pin_chk(6'h03, 6'h00);
        apb(1'b1, gate_cond_pkg::OFS_MASK_EN, 32'h3F);
        apb(1'b1, gate_cond_pkg::OFS_MASK_VAL, 32'h2A);
        pin_chk(6'h15, 6'h2A);
        apb(1'b1, gate_cond_pkg::OFS_MASK_VAL, 32'h03);
        pin_chk(6'h15, 6'h00);
        apb(1'b1, gate_cond_pkg::OFS_MASK_EN, 32'h01);
        apb(1'b1, gate_cond_pkg::OFS_MASK_VAL, 32'h00);
        pin_chk(6'h15, 6'h14);
        hw_mask <= 6'h24;
        apb(1'b1, gate_cond_pkg::OFS_MODE_CTRL, 32'h10);
        pin_chk(6'h15, 6'h24);
        apb(1'b1, gate_cond_pkg::OFS_MASK_EN, 32'h00);
        protect <= 1'b1;
        apb(1'b1, gate_cond_pkg::OFS_MODE_CTRL, 32'h13);
        pin_chk(6'h15, 6'h2A);
        apb(1'b1, gate_cond_pkg::OFS_MODE_CTRL, 32'h11);
        pin_chk(6'h15, 6'h00);
        apb(1'b1, gate_cond_pkg::OFS_MODE_CTRL, 32'h15);
        pin_chk(6'h15, 6'h2A);
        protect <= 1'b0;
        apb(1'b1, gate_cond_pkg::OFS_MODE_CTRL, 32'h11);
        apb(1'b1, gate_cond_pkg::OFS_POLARITY, 32'h03);
        pin_chk(6'h15, 6'h16);
        apb(1'b1, gate_cond_pkg::OFS_POLARITY, 32'h00);
        hall_s <= 3'h3;
        hall_a <= 3'h6;
        apb(1'b1, gate_cond_pkg::OFS_HALL_DATA, 32'h5);
        repeat (6) @(posedge clk_i);
        #1 chk("hall decoder", 32'h5, {29'h0, hall_dec});
        apb(1'b1, gate_cond_pkg::OFS_MODE_CTRL, 32'h19);
        repeat (6) @(posedge clk_i);
        #1 chk("hall decoder", 32'h3, {29'h0, hall_dec});
        hall_sel <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1 chk("hall decoder", 32'h6, {29'h0, hall_dec});
        apb(1'b1, gate_cond_pkg::OFS_MODE_CTRL, 32'h11);
        // Full rate cannot reach the minimum dead time at this clock
        dt_run(2'b10, 5'd31, 4);
        dt_run(2'b01, 5'd31, 2);
        dt_run(2'b10, 5'd15, 4);
        dt_run(2'b11, 5'd7, 8);
        apb(1'b1, gate_cond_pkg::OFS_DEAD_TIME, 32'hC7);
        pin_chk(6'h01, 6'h01);
        chk("pair short", 32'h0, {31'h0, shoot});
        test_done();
    end
endmodule
`default_nettype wire
